/* File: serdes_rx_defines.svh */
`ifndef SERDES_RX_DEFINES_SVH
`define SERDES_RX_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL         12'h000
`define OFS_STATUS       12'h004
`define OFS_WORD_LO      12'h008
`define OFS_WORD_HI      12'h00c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_BYTE_EN     0
`define CTRL_XAUI        1
`define CTRL_DECODE      2
`define CTRL_FORCE       3
`define CTRL_HOLD        4
`define CTRL_CKSEL_LO    5
`define CTRL_RESET       32'h0000_0004

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_WSYNC       0
`define STAT_LINK        1
`define STAT_COMMA       2
`define STAT_CV          3
`define STAT_CDR         4

// ----------------------------------------
// Code points
// ----------------------------------------
`define COMMA_POS        7'h7c
`define COMMA_NEG        7'h03
`define K28_5_BYTE       8'hbc
`define ALIGN_A_BYTE     8'h7c

// ----------------------------------------
// Sync thresholds
// ----------------------------------------
`define SETS_TO_SYNC     3'h3
`define BAD_TO_LOSS      3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS           50
`define REF_HOLD_NS      2000
`define TRY_NS           1000
`define REF_HOLD_CYC     ((`REF_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define TRY_CYC          (`TRY_NS / `CLK_NS)

`endif

/* File: serdes_rx_pkg.sv */
package serdes_rx_pkg;

	typedef enum logic [1:0] {
		CDR_REF  = 2'h0,
		CDR_TRY  = 2'h1,
		CDR_DATA = 2'h3
	} cdr_state_t;

	typedef enum logic [1:0] {
		SYN_LOS  = 2'h0,
		SYN_ACQ  = 2'h1,
		SYN_OK   = 2'h3
	} sync_state_t;

	typedef struct packed {
		logic [39:0] wide_rx_word;
		logic [3:0]  special_flag_lanes;
		logic [3:0]  bit9_lanes;
		logic [3:0]  sync_event_position;
	} rx_word_t;

endpackage

/* File: serdes_rx_alignment_demux.sv */
`timescale 1ns/10ps
`include "serdes_rx_defines.svh"


module serdes_rx_alignment_demux import serdes_rx_pkg::*; #(
	parameter int REF_HOLD_CYC = `REF_HOLD_CYC,
	parameter int TRY_CYC      = `TRY_CYC
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  rx_bits,
	input  wire logic        cdr_data_valid,
	input  wire logic [2:0]  rx_quarter_peers,
	output logic             cdr_lock_to_data,
	output logic             word_sync_flag,
	output logic [9:0]       decoded_char_bus,
	output rx_word_t         rx_word,
	output logic             rx_word_valid,
	output logic             rx_quarter_clock
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [4:0] find_comma(input logic [19:0] w);
		logic [4:0] r;
		r = 5'h00;
		for (int k = 9; k >= 0; k--) begin
			if (w[k +: 7] == `COMMA_POS || w[k +: 7] == `COMMA_NEG) begin
				r = {1'b1, 4'(k)};
			end
		end
		return r;
	endfunction

	// Returns {violation, special, byte}; disparity itself is not tracked
	function automatic logic [9:0] decode_char(input logic [9:0] c);
		logic [5:0] s;
		logic [3:0] f;
		logic [5:0] lo;
		logic [3:0] hi;
		logic       k;
		s = {c[0], c[1], c[2], c[3], c[4], c[5]};
		f = {c[6], c[7], c[8], c[9]};
		k = (s == 6'h0f) || (s == 6'h30);
		if (s == 6'h30) begin
			f = ~f;
		end
		case (s)
			6'h27, 6'h18: lo = 6'h20;
			6'h1d, 6'h22: lo = 6'h21;
			6'h2d, 6'h12: lo = 6'h22;
			6'h31: lo = 6'h23;
			6'h35, 6'h0a: lo = 6'h24;
			6'h29: lo = 6'h25;
			6'h19: lo = 6'h26;
			6'h38, 6'h07: lo = 6'h27;
			6'h39, 6'h06: lo = 6'h28;
			6'h25: lo = 6'h29;
			6'h15: lo = 6'h2a;
			6'h34: lo = 6'h2b;
			6'h0d: lo = 6'h2c;
			6'h2c: lo = 6'h2d;
			6'h1c: lo = 6'h2e;
			6'h17, 6'h28: lo = 6'h2f;
			6'h1b, 6'h24: lo = 6'h30;
			6'h23: lo = 6'h31;
			6'h13: lo = 6'h32;
			6'h32: lo = 6'h33;
			6'h0b: lo = 6'h34;
			6'h2a: lo = 6'h35;
			6'h1a: lo = 6'h36;
			6'h3a, 6'h05: lo = 6'h37;
			6'h33, 6'h0c: lo = 6'h38;
			6'h26: lo = 6'h39;
			6'h16: lo = 6'h3a;
			6'h36, 6'h09: lo = 6'h3b;
			6'h0e, 6'h0f, 6'h30: lo = 6'h3c;
			6'h2e, 6'h11: lo = 6'h3d;
			6'h1e, 6'h21: lo = 6'h3e;
			6'h2b, 6'h14: lo = 6'h3f;
			default: lo = 6'h00;
		endcase
		case (f)
			4'hb, 4'h4: hi = 4'h8;
			4'h9: hi = 4'h9;
			4'h5: hi = 4'ha;
			4'hc, 4'h3: hi = 4'hb;
			4'hd, 4'h2: hi = 4'hc;
			4'ha: hi = 4'hd;
			4'h6: hi = 4'he;
			4'he, 4'h1, 4'h7, 4'h8: hi = 4'hf;
			default: hi = 4'h0;
		endcase
		if ((f == 4'h7 || f == 4'h8) && (lo == 6'h37 || lo == 6'h3b || lo == 6'h3d
				|| lo == 6'h3e)) begin
			k = 1'b1;
		end
		return {~(lo[5] & hi[3]), k, hi[2:0], lo[4:0]};
	endfunction

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [31:0] ctrl_r;
	logic        comma_seen_r;
	logic        cv_seen_r;
	logic        setup;
	logic        wr_acc;
	logic        mapped;
	logic        synced;
	cdr_state_t  cdr_st_r;

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pready;
	assign mapped = paddr == `OFS_CTRL || paddr == `OFS_STATUS || paddr == `OFS_WORD_LO
		|| paddr == `OFS_WORD_HI;

	// Answer one cycle after setup keeps prdata straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				case (paddr)
					`OFS_CTRL:    prdata <= ctrl_r;
					`OFS_STATUS:  prdata <= {27'h0000000, cdr_st_r == CDR_DATA, cv_seen_r,
						comma_seen_r, synced, synced};
					`OFS_WORD_LO: prdata <= rx_word.wide_rx_word[31:0];
					`OFS_WORD_HI: prdata <= {12'h000, rx_word.sync_event_position,
						rx_word.bit9_lanes, rx_word.special_flag_lanes,
						rx_word.wide_rx_word[39:32]};
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `CTRL_RESET;
		end else if (wr_acc && paddr == `OFS_CTRL) begin
			ctrl_r <= {25'h0000000, pwdata[6:0]};
		end
	end

	logic       byte_align_enable;
	logic       lane_protocol_select;
	logic       decode_enable;
	logic       force_realign;
	logic       hold_boundary;
	logic [1:0] rx_clock_source_select;

	assign byte_align_enable      = ctrl_r[`CTRL_BYTE_EN];
	assign lane_protocol_select   = ctrl_r[`CTRL_XAUI];
	assign decode_enable          = ctrl_r[`CTRL_DECODE];
	assign force_realign          = ctrl_r[`CTRL_FORCE];
	assign hold_boundary          = ctrl_r[`CTRL_HOLD];
	assign rx_clock_source_select = ctrl_r[`CTRL_CKSEL_LO +: 2];

	// ----------------------------------------
	// Clock recovery fallback
	// ----------------------------------------
	logic [31:0] cdr_tmr_r;
	logic        locked;

	assign locked = cdr_st_r == CDR_DATA;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cdr_st_r  <= CDR_REF;
			cdr_tmr_r <= 32'h0000_0000;
		end else begin
			cdr_tmr_r <= cdr_tmr_r + 32'h0000_0001;
			case (cdr_st_r)
				CDR_REF: if (cdr_tmr_r >= 32'(REF_HOLD_CYC - 1)) begin
					cdr_st_r  <= CDR_TRY;
					cdr_tmr_r <= 32'h0000_0000;
				end
				CDR_TRY: if (cdr_data_valid) begin
					cdr_st_r <= CDR_DATA;
				end else if (cdr_tmr_r >= 32'(TRY_CYC - 1)) begin
					cdr_st_r  <= CDR_REF;
					cdr_tmr_r <= 32'h0000_0000;
				end
				CDR_DATA: if (!cdr_data_valid) begin
					cdr_st_r  <= CDR_REF;
					cdr_tmr_r <= 32'h0000_0000;
				end
				default: cdr_st_r <= CDR_REF;
			endcase
		end
	end

	// ----------------------------------------
	// Byte aligner
	// ----------------------------------------
	logic [9:0]  prev_r;
	logic [3:0]  offset_r;
	logic        pending_r;
	logic        en_d_r;
	logic [9:0]  char_r;
	logic [4:0]  hit;
	logic        armed;
	logic        do_align;
	logic [19:0] window;

	assign window   = {rx_bits, prev_r};
	assign hit      = find_comma(window);
	assign armed    = byte_align_enable || pending_r;
	assign do_align = locked && hit[4] && armed;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r    <= 10'h000;
			offset_r  <= 4'h0;
			pending_r <= 1'b0;
			en_d_r    <= 1'b0;
			char_r    <= 10'h000;
		end else begin
			prev_r <= rx_bits;
			en_d_r <= byte_align_enable;
			if (do_align) begin
				offset_r <= hit[3:0];
				char_r   <= window[hit[3:0] +: 10];
				pending_r <= 1'b0;
			end else begin
				char_r <= window[offset_r +: 10];
				if (byte_align_enable && !en_d_r) begin
					pending_r <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Decode and link sync
	// ----------------------------------------
	logic [9:0]  dec;
	logic        is_comma;
	logic        comma_ok;
	logic        cv;
	logic        evt;
	sync_state_t syn_st_r;
	logic [2:0]  cnt_r;
	logic [2:0]  bad_r;
	logic        good_r;

	assign dec      = decode_char(char_r);
	assign cv       = dec[9];
	assign is_comma = char_r[6:0] == `COMMA_POS || char_r[6:0] == `COMMA_NEG;
	assign comma_ok = is_comma && !cv && (lane_protocol_select
		|| dec[7:0] == `K28_5_BYTE);
	assign synced   = syn_st_r == SYN_OK;
	// XAUI aligns on /A/, which needs decoded characters
	assign evt      = lane_protocol_select ? (decode_enable && dec[8]
		&& dec[7:0] == `ALIGN_A_BYTE) : is_comma;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syn_st_r <= SYN_LOS;
			cnt_r    <= 3'h0;
			bad_r    <= 3'h0;
			good_r   <= 1'b0;
		end else if (!locked) begin
			syn_st_r <= SYN_LOS;
			cnt_r    <= 3'h0;
		end else begin
			case (syn_st_r)
				SYN_LOS: if (comma_ok) begin
					syn_st_r <= SYN_ACQ;
					cnt_r    <= 3'h1;
				end
				SYN_ACQ: if (cv) begin
					syn_st_r <= SYN_LOS;
					cnt_r    <= 3'h0;
				end else if (comma_ok) begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r + 3'h1 == `SETS_TO_SYNC) begin
						syn_st_r <= SYN_OK;
						bad_r    <= 3'h0;
						good_r   <= 1'b0;
					end
				end
				SYN_OK: if (cv) begin
					good_r <= 1'b0;
					bad_r  <= bad_r + 3'h1;
					if (bad_r + 3'h1 == `BAD_TO_LOSS) begin
						syn_st_r <= SYN_LOS;
						cnt_r    <= 3'h0;
					end
				end else if (good_r && bad_r != 3'h0) begin
					bad_r  <= bad_r - 3'h1;
					good_r <= 1'b0;
				end else begin
					good_r <= bad_r != 3'h0;
				end
				default: syn_st_r <= SYN_LOS;
			endcase
		end
	end

	// ----------------------------------------
	// Character output and sticky status
	// ----------------------------------------
	logic evt_r;
	logic synced_d_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decoded_char_bus <= 10'h000;
			evt_r            <= 1'b0;
			word_sync_flag   <= 1'b0;
			synced_d_r       <= 1'b0;
			cdr_lock_to_data <= 1'b0;
		end else begin
			decoded_char_bus <= decode_enable ? dec : char_r;
			evt_r            <= evt;
			word_sync_flag   <= synced;
			synced_d_r       <= word_sync_flag;
			cdr_lock_to_data <= locked;
		end
	end

	// Hardware set wins over a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comma_seen_r <= 1'b0;
			cv_seen_r    <= 1'b0;
		end else begin
			comma_seen_r <= (locked && is_comma) || (comma_seen_r
				&& !(wr_acc && paddr == `OFS_STATUS && pwdata[`STAT_COMMA]));
			cv_seen_r    <= (locked && cv && decode_enable) || (cv_seen_r
				&& !(wr_acc && paddr == `OFS_STATUS && pwdata[`STAT_CV]));
		end
	end

	// ----------------------------------------
	// 1:4 demultiplexer
	// ----------------------------------------
	logic [9:0] lane_r [3];
	logic [1:0] slot_r;
	logic [3:0] pos_r;
	logic       search_r;
	logic       force_d_r;
	logic       align_now;
	logic [1:0] slot_use;
	logic [3:0] pos_nxt;

	assign align_now = search_r && word_sync_flag && !hold_boundary && evt_r;
	assign slot_use  = align_now ? 2'h0 : slot_r;
	assign pos_nxt   = (slot_use == 2'h0 ? 4'h0 : pos_r)
		| ((evt_r && word_sync_flag) ? 4'h8 >> slot_use : 4'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			search_r  <= 1'b1;
			force_d_r <= 1'b0;
		end else begin
			force_d_r <= force_realign;
			if (!synced_d_r || (force_realign && !force_d_r)) begin
				search_r <= 1'b1;
			end else if (align_now) begin
				search_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_r        <= 2'h0;
			pos_r         <= 4'h0;
			lane_r        <= '{default: 10'h000};
			rx_word       <= '0;
			rx_word_valid <= 1'b0;
		end else begin
			slot_r        <= slot_use + 2'h1;
			pos_r         <= pos_nxt;
			rx_word_valid <= slot_use == 2'h3;
			if (slot_use != 2'h3) begin
				lane_r[slot_use] <= decoded_char_bus;
			end else begin
				rx_word.wide_rx_word <= {lane_r[0], lane_r[1], lane_r[2],
					decoded_char_bus};
				rx_word.special_flag_lanes <= {lane_r[0][8], lane_r[1][8], lane_r[2][8],
					decoded_char_bus[8]};
				rx_word.bit9_lanes <= {lane_r[0][9], lane_r[1][9], lane_r[2][9],
					decoded_char_bus[9]};
				rx_word.sync_event_position <= word_sync_flag ? pos_nxt : 4'h0;
			end
		end
	end

	// Own source divides the character rate by four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_quarter_clock <= 1'b0;
		end else begin
			case (rx_clock_source_select)
				2'h0:    rx_quarter_clock <= ~slot_r[1];
				2'h1:    rx_quarter_clock <= rx_quarter_peers[0];
				2'h2:    rx_quarter_clock <= rx_quarter_peers[1];
				default: rx_quarter_clock <= rx_quarter_peers[2];
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_word_out;
		rx_word_valid;
	endsequence

	sequence s_force_edge;
		force_realign && !force_d_r && synced_d_r;
	endsequence

	a_cdr_fallback_ref: assert property (@(posedge pclk) disable iff (!presetn)
		locked && !cdr_data_valid |=> cdr_st_r == CDR_REF)
		else $error("data lock kept without valid data");

	a_byte_late_arm: assert property (@(posedge pclk) disable iff (!presetn)
		byte_align_enable && !en_d_r && !do_align |=> pending_r)
		else $error("late alignment not armed");

	a_byte_lock_one: assert property (@(posedge pclk) disable iff (!presetn)
		do_align |=> offset_r == $past(hit[3:0]))
		else $error("comma boundary not taken at once");

	a_sync_three_sets: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(synced) |-> $past(cnt_r) == 3'h2 && $past(syn_st_r) == SYN_ACQ)
		else $error("sync declared on wrong count");

	a_loss_after_four: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(synced) && $past(locked) |-> $past(bad_r) == 3'h3)
		else $error("sync lost on wrong bad count");

	a_hold_freezes: assert property (@(posedge pclk) disable iff (!presetn)
		hold_boundary |=> slot_r == 2'($past(slot_r) + 2'h1))
		else $error("boundary moved under hold");

	a_comma_top_byte: assert property (@(posedge pclk) disable iff (!presetn)
		align_now |=> slot_r == 2'h1 ##3 rx_word_valid)
		else $error("aligned comma not leading word");

	a_word_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		s_word_out |=> !rx_word_valid [*3])
		else $error("words closer than four characters");

	a_force_search: assert property (@(posedge pclk) disable iff (!presetn)
		s_force_edge |=> search_r)
		else $error("force edge did not restart search");

	a_pos_unsynced: assert property (@(posedge pclk) disable iff (!presetn)
		s_word_out and !$past(word_sync_flag) |-> rx_word.sync_event_position == 4'h0)
		else $error("event position set without sync");

endmodule

/* File: serdes_far_tx.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Far-end transmitter: idle ordered sets
// ----------------------------------------
module serdes_far_tx (
	input  wire logic       pclk,
	input  wire logic       run,
	input  wire logic [3:0] slip,
	input  wire logic       extra,
	input  wire logic       bad,
	output logic      [9:0] rx_bits
);
	logic [19:0] sh_r;
	logic [2:0]  cnt_r;
	logic        rd_r;
	logic        xtra_r;
	logic [9:0]  chr;

	initial begin
		sh_r = 20'h0;
		cnt_r = 3'h0;
		rd_r = 1'b0;
		xtra_r = 1'b0;
		rx_bits = 10'h2aa;
	end

	always_comb begin
		chr = 10'h155;
		if (cnt_r == 3'h0)
			chr = rd_r ? 10'h283 : 10'h17c;
		if (bad)
			chr = 10'h000;
	end

	// One extra filler character shifts the comma off the word boundary
	always @(posedge pclk) begin
		sh_r <= {chr, sh_r[19:10]};
		if (extra)
			xtra_r <= 1'b1;
		if (cnt_r == 3'h4)
			xtra_r <= 1'b0;
		if ((cnt_r == 3'h3 && !xtra_r) || cnt_r == 3'h4)
			cnt_r <= 3'h0;
		else
			cnt_r <= cnt_r + 3'h1;
		if (cnt_r == 3'h0)
			rd_r <= ~rd_r;
	end

	// Bit phase is arbitrary; an idle line toggles so no stale value lingers
	always @(posedge pclk)
		rx_bits <= run ? sh_r[slip +: 10] : ~rx_bits;
endmodule

/* File: serdes_rx_alignment_demux_tb_top.sv */
`timescale 1ns/10ps
module serdes_rx_alignment_demux_tb_top import serdes_rx_pkg::*; ;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel, penable, pwrite, pready, pslverr, err_seen, pq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic        cdr_data_valid, cdr_lock_to_data, word_sync_flag;
	logic        rx_word_valid, rx_quarter_clock, extra, bad;
	logic [9:0]  rx_bits, decoded_char_bus;
	logic [2:0]  rx_quarter_peers;
	logic [3:0]  slip;
	rx_word_t    rx_word;
	rx_word_t    exp_q[$];
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n;

	serdes_rx_alignment_demux #(.REF_HOLD_CYC(4), .TRY_CYC(3)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_bits(rx_bits),
		.cdr_data_valid(cdr_data_valid), .rx_quarter_peers(rx_quarter_peers),
		.cdr_lock_to_data(cdr_lock_to_data), .word_sync_flag(word_sync_flag),
		.decoded_char_bus(decoded_char_bus), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .rx_quarter_clock(rx_quarter_clock));

	serdes_far_tx far_u (.pclk(pclk), .run(cdr_data_valid), .slip(slip),
		.extra(extra), .bad(bad), .rx_bits(rx_bits));

	always #25 pclk = ~pclk;

	always @(posedge pclk)
		rx_quarter_peers <= 3'($urandom);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [51:0] seen, input logic [51:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd_data = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", k < 50, 1'b1);
	endtask

	task automatic wait_on(ref logic s, input logic v);
		int k;
		for (k = 0; k < 3000 && s !== v; k++)
			@(negedge pclk);
		check("wait", s, v);
	endtask

	function automatic rx_word_t mk(input logic [3:0] sp, input logic [3:0] ps);
		rx_word_t w;
		for (int i = 0; i < 4; i++)
			w.wide_rx_word[i*10 +: 10] = sp[i] ? 10'h1bc : 10'h0b5;
		w.special_flag_lanes = sp;
		w.bit9_lanes = 4'h0;
		w.sync_event_position = ps;
		return w;
	endfunction

	// Stream is periodic, so any settled word must match the note
	task automatic expect_words(input rx_word_t w);
		repeat (3) begin
			wait_on(rx_word_valid, 1'b1);
			@(negedge pclk);
		end
		repeat (3) exp_q.push_back(w);
		for (n = 0; n < 200 && exp_q.size() > 0; n++)
			@(negedge pclk);
		check("words left", exp_q.size(), 0);
	endtask

	task automatic lose_sync;
		@(posedge pclk);
		bad <= 1'b1;
		wait_on(word_sync_flag, 1'b0);
		wait_on(rx_word_valid, 1'b1);
		check("event pos", rx_word.sync_event_position, 4'h0);
		@(posedge pclk);
		bad <= 1'b0;
		wait_on(word_sync_flag, 1'b1);
	endtask

	task automatic slip_char;
		@(posedge pclk);
		extra <= 1'b1;
		@(posedge pclk);
		extra <= 1'b0;
	endtask

	always @(negedge pclk)
		if (rx_word_valid === 1'b1 && exp_q.size() > 0)
			check("rx_word", rx_word, exp_q.pop_front());

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			give_verdict;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cdr_data_valid = 1'b0;
		rx_quarter_peers = 3'h0;
		slip = 4'h0;
		extra = 1'b0;
		bad = 1'b0;
		n = $urandom(32'hb57755f8);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl reset", rd_data, 32'h4);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", {err_seen, rd_data}, 33'h100000000);
		n = 0;
		repeat (40) begin
			@(negedge pclk);
			n += (cdr_lock_to_data === 1'b0);
		end
		check("ref lock", n, 40);
		@(posedge pclk);
		slip <= 4'($urandom_range(9));
		cdr_data_valid <= 1'b1;
		wait_on(cdr_lock_to_data, 1'b1);
		apb(1'b1, 12'h000, 32'h5);
		wait_on(word_sync_flag, 1'b1);
		expect_words(mk(4'b1000, 4'b1000));
		apb(1'b0, 12'h004, 32'h0);
		check("status", rd_data[1:0], 2'b11);
		slip_char;
		expect_words(mk(4'b0100, 4'b0100));
		apb(1'b1, 12'h000, 32'hd);
		expect_words(mk(4'b1000, 4'b1000));
		apb(1'b1, 12'h000, 32'h15);
		slip_char;
		lose_sync;
		expect_words(mk(4'b0100, 4'b0100));
		apb(1'b1, 12'h000, 32'h5);
		slip_char;
		lose_sync;
		expect_words(mk(4'b1000, 4'b1000));
		apb(1'b1, 12'h000, 32'h7);
		lose_sync;
		apb(1'b1, 12'h000, 32'h45);
		repeat (3) @(negedge pclk);
		repeat (8) begin
			pq = rx_quarter_peers[1];
			@(negedge pclk);
			check("quarter clock", rx_quarter_clock, pq);
		end
		give_verdict;
	end
endmodule
